/* hw/slmb_btn.sv */
`timescale 1ns/1ns
module slmb_btn #(
    parameter int unsigned DEB_CYC  = slmb_pkg::DEB_CYC_DEF,
    parameter int unsigned LONG_CYC = slmb_pkg::LONG_CYC_DEF
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // Button pin, low while pressed
    input  wire logic button_n,
    // Press events
    output logic      short_press,
    output logic      long_press,
    output logic      boot_held
);
    import slmb_pkg::*;

    // Hold time is counted after the debounced press, which already spent DEB_CYC
    localparam int unsigned HOLD_CYC = LONG_CYC - DEB_CYC;

    logic        btn_m_q;
    logic        btn_s_q;
    logic        db_q;
    logic        boot_q;
    logic [31:0] deb_cnt_q;
    logic [31:0] hold_cnt_q;
    slmb_btn_t   state_q;
    logic        deb_done;
    logic        db_rise;
    logic        db_fall;

    // Two-stage synchroniser, inverted so that one means pressed
    always_ff @(posedge mclk) begin
        if (reset) begin
            btn_m_q <= 1'b0;
            btn_s_q <= 1'b0;
        end else begin
            btn_m_q <= ~button_n;
            btn_s_q <= btn_m_q;
        end
    end

    // During the boot window the counter runs freely and samples once at its end
    assign deb_done = (deb_cnt_q == DEB_CYC - 1);
    assign db_rise  = deb_done && btn_s_q && !db_q;
    assign db_fall  = deb_done && !btn_s_q && db_q;

    // Debounce: level must hold DEB_CYC cycles before it is taken
    always_ff @(posedge mclk) begin
        if (reset) begin
            deb_cnt_q <= 32'h0000_0000;
            db_q      <= 1'b0;
            boot_q    <= 1'b1;
        end else if (!boot_q && btn_s_q == db_q) begin
            deb_cnt_q <= 32'h0000_0000;
        end else if (deb_done) begin
            deb_cnt_q <= 32'h0000_0000;
            db_q      <= btn_s_q;
            boot_q    <= 1'b0;
        end else begin
            deb_cnt_q <= deb_cnt_q + 32'h0000_0001;
        end
    end

    // Press tracker; a press held through power-up never reports a short press
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q     <= SLMB_BTN_IDLE;
            hold_cnt_q  <= 32'h0000_0000;
            short_press <= 1'b0;
            long_press  <= 1'b0;
            boot_held   <= 1'b0;
        end else begin
            short_press <= 1'b0;
            long_press  <= 1'b0;
            boot_held   <= 1'b0;
            case (state_q)
                SLMB_BTN_IDLE: begin
                    hold_cnt_q <= 32'h0000_0000;
                    if (db_rise && boot_q) begin
                        boot_held <= 1'b1;
                        state_q   <= SLMB_BTN_LONG;
                    end else if (db_rise) begin
                        state_q <= SLMB_BTN_HELD;
                    end
                end
                SLMB_BTN_HELD: begin
                    if (db_fall) begin
                        short_press <= 1'b1;
                        state_q     <= SLMB_BTN_IDLE;
                    end else if (hold_cnt_q == HOLD_CYC - 1) begin
                        long_press <= 1'b1;
                        state_q    <= SLMB_BTN_LONG;
                    end else begin
                        hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
                    end
                end
                SLMB_BTN_LONG: begin
                    if (db_fall) begin
                        state_q <= SLMB_BTN_IDLE;
                    end
                end
                default: begin
                    state_q <= SLMB_BTN_IDLE;
                end
            endcase
        end
    end

    // Debounced level only moves after a full stable count
    AST_DEB_STABLE: assert property (@(posedge mclk) disable iff (reset)
        (db_q != $past(db_q)) |-> ($past(deb_cnt_q) == DEB_CYC - 1))
        else $error("debounced level moved before stable count");

    // A short press only ends a held, not-yet-long press
    AST_SHORT_FROM_HELD: assert property (@(posedge mclk) disable iff (reset)
        short_press |-> ($past(state_q) == SLMB_BTN_HELD && !db_q))
        else $error("short press outside held state");
endmodule

/* hw/slmb_pkg.sv */
package slmb_pkg;
    // Clock rate and printed times
    localparam longint unsigned CLK_HZ   = 64'd250_000_000;
    localparam int unsigned     DEB_MS   = 20;
    localparam int unsigned     LONG_MS  = 1000;
    localparam int unsigned     TICK_MS  = 100;
    localparam int unsigned     MSEC_MS  = 1;

    // Cycle counts, least times rounded up
    localparam int unsigned DEB_CYC_DEF  = 32'((64'(DEB_MS) * CLK_HZ + 64'd999) / 64'd1000);
    localparam int unsigned LONG_CYC_DEF = 32'((64'(LONG_MS) * CLK_HZ + 64'd999) / 64'd1000);
    localparam int unsigned TICK_CYC_DEF = 32'((64'(TICK_MS) * CLK_HZ + 64'd999) / 64'd1000);
    localparam int unsigned MS_CYC_DEF   = 32'((64'(MSEC_MS) * CLK_HZ + 64'd999) / 64'd1000);

    // Port counts and pulse limits
    localparam int unsigned NPORTS       = 8;
    localparam logic [13:0] PULSE_MIN_MS = 14'h0001;
    localparam logic [13:0] PULSE_MAX_MS = 14'h2710;

    // Lamp frame of 100 ms ticks: 20 ticks, one flash per second, burst of four
    localparam logic [4:0] FRAME_LAST  = 5'h13;
    localparam logic [4:0] SEC_TICK    = 5'h0A;
    localparam logic [4:0] BURST_TICKS = 5'h08;

    // Operating modes
    typedef enum logic [1:0] {
        SLMB_NORMAL     = 2'h0,
        SLMB_SERIAL_CFG = 2'h1,
        SLMB_FW_UPDATE  = 2'h3
    } slmb_mode_t;

    // Button press tracker states
    typedef enum logic [1:0] {
        SLMB_BTN_IDLE = 2'h0,
        SLMB_BTN_HELD = 2'h1,
        SLMB_BTN_LONG = 2'h3
    } slmb_btn_t;

    // Relay level command
    typedef struct packed {
        logic       valid;
        logic [2:0] port;
        logic       value;
    } slmb_lvl_cmd_t;

    // Relay pulse command, time in ms
    typedef struct packed {
        logic        valid;
        logic [2:0]  port;
        logic [13:0] ms;
    } slmb_pls_cmd_t;

    // Front-panel lamps
    typedef struct packed {
        logic       link_green;
        logic       link_red;
        logic       rx_lamp;
        logic       tx_lamp;
        logic       state_lamp;
        logic [7:0] input_lamp;
        logic [7:0] output_lamp;
    } slmb_lamps_t;
endpackage

/* hw/slmb_top.sv */
`timescale 1ns/1ns
// Summary of operation
// - Link lamp green at 100 Mbit/s, red at 10 Mbit/s.
// - Receive lamp blinks while Ethernet frames arrive.
// - Transmit lamp blinks while frames go out to Ethernet.
// - Normal mode with address assigned and no Modbus connection: state lamp flashes once a second; lit steadily while connected.
// - Normal mode without assigned address or Modbus connection: state lamp flashes in bursts of four.
// - Normal mode: each input lamp lit while its input is on.
// - Normal mode: each output lamp lit while its relay is on.
// - Serial configuration: link, state, receive, transmit lamps blink in phase.
// - Firmware-update mode keeps the state lamp off.
// - Press held 20 ms to 1 s then released enters serial configuration.
// - Press over 1 s, or held at power-up, enters firmware update.
// - Level command drives relay i on for 1, off for 0.
// - Pulse command drives relay i on for 1 to 10000 ms.
// - Output value 0 opens the relay contact, 1 closes it.
module slmb_top #(
    parameter int unsigned DEB_CYC  = slmb_pkg::DEB_CYC_DEF,
    parameter int unsigned LONG_CYC = slmb_pkg::LONG_CYC_DEF,
    parameter int unsigned TICK_CYC = slmb_pkg::TICK_CYC_DEF,
    parameter int unsigned MS_CYC   = slmb_pkg::MS_CYC_DEF
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // Network status from the stack
    input  wire logic                  link_up,
    input  wire logic                  link_100m,
    input  wire logic                  rx_active,
    input  wire logic                  tx_active,
    input  wire logic                  addr_assigned,
    input  wire logic                  modbus_connected,
    // Field pins
    input  wire logic [7:0]            digital_in,
    input  wire logic                  mode_button_n,
    // Relay commands
    input  wire slmb_pkg::slmb_lvl_cmd_t output_level_cmd,
    input  wire slmb_pkg::slmb_pls_cmd_t output_pulse_cmd,
    // Relays and lamps
    output logic [7:0]                 relay_out,
    output slmb_pkg::slmb_lamps_t      lamps,
    // Mode and status
    output slmb_pkg::slmb_mode_t       op_mode,
    output logic                       serial_config_mode,
    output logic                       firmware_update_mode,
    output logic                       pulse_reject
);
    import slmb_pkg::*;

    logic [7:0]  din_m_q;
    logic [7:0]  din_s_q;
    logic [31:0] tick_cnt_q;
    logic [31:0] ms_cnt_q;
    logic        ms_tick;
    logic        frame_tick;
    logic [4:0]  frame_q;
    slmb_mode_t  mode_q;
    slmb_lamps_t lamps_q;
    slmb_lamps_t lamps_d;
    logic        short_press;
    logic        long_press;
    logic        boot_held;
    logic        pls_ok;
    logic        reject_q;
    wire  [7:0]  relay_w;
    logic        act_phase;
    logic        ser_blink;
    logic        sec_flash;
    logic        burst_flash;

    // Digital inputs come from isolated field pins
    always_ff @(posedge mclk) begin
        if (reset) begin
            din_m_q <= 8'h00;
            din_s_q <= 8'h00;
        end else begin
            din_m_q <= digital_in;
            din_s_q <= din_m_q;
        end
    end

    // Button timing lives in its own module
    slmb_btn #(
        .DEB_CYC  (DEB_CYC),
        .LONG_CYC (LONG_CYC)
    ) u_btn (
        .mclk        (mclk),
        .reset       (reset),
        .button_n    (mode_button_n),
        .short_press (short_press),
        .long_press  (long_press),
        .boot_held   (boot_held)
    );

    // Mode: firmware update is left only by reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_q <= SLMB_NORMAL;
        end else begin
            case (mode_q)
                SLMB_NORMAL: begin
                    if (long_press || boot_held) begin
                        mode_q <= SLMB_FW_UPDATE;
                    end else if (short_press) begin
                        mode_q <= SLMB_SERIAL_CFG;
                    end
                end
                SLMB_SERIAL_CFG: begin
                    if (long_press) begin
                        mode_q <= SLMB_FW_UPDATE;
                    end
                end
                SLMB_FW_UPDATE: begin
                    mode_q <= SLMB_FW_UPDATE;
                end
                default: begin
                    mode_q <= SLMB_NORMAL;
                end
            endcase
        end
    end

    // 100 ms lamp tick and 1 ms relay tick, both free running
    assign frame_tick = (tick_cnt_q == TICK_CYC - 1);
    assign ms_tick    = (ms_cnt_q == MS_CYC - 1);

    always_ff @(posedge mclk) begin
        if (reset || frame_tick) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || ms_tick) begin
            ms_cnt_q <= 32'h0000_0000;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
        end
    end

    // Two-second lamp frame shared by all blinkers, so they stay in phase
    always_ff @(posedge mclk) begin
        if (reset) begin
            frame_q <= 5'h00;
        end else if (frame_tick) begin
            frame_q <= (frame_q == FRAME_LAST) ? 5'h00 : frame_q + 5'h01;
        end
    end

    // Blink patterns taken from the frame position
    assign act_phase   = frame_q[0];
    assign ser_blink   = (frame_q < SEC_TICK);
    assign sec_flash   = (frame_q == 5'h00) || (frame_q == SEC_TICK);
    assign burst_flash = (frame_q < BURST_TICKS) && !frame_q[0];

    // Lamp selection per mode
    always_comb begin
        lamps_d            = '0;
        lamps_d.link_green = link_up && link_100m;
        lamps_d.link_red   = link_up && !link_100m;
        lamps_d.rx_lamp    = rx_active && act_phase;
        lamps_d.tx_lamp    = tx_active && act_phase;
        case (mode_q)
            SLMB_NORMAL: begin
                if (modbus_connected) begin
                    lamps_d.state_lamp = 1'b1;
                end else if (addr_assigned) begin
                    lamps_d.state_lamp = sec_flash;
                end else begin
                    lamps_d.state_lamp = burst_flash;
                end
                lamps_d.input_lamp  = din_s_q;
                lamps_d.output_lamp = relay_w;
            end
            SLMB_SERIAL_CFG: begin
                // Link lamp keeps its speed colour while it blinks
                lamps_d.link_green = ser_blink && link_100m;
                lamps_d.link_red   = ser_blink && !link_100m;
                lamps_d.state_lamp = ser_blink;
                lamps_d.rx_lamp    = ser_blink;
                lamps_d.tx_lamp    = ser_blink;
            end
            SLMB_FW_UPDATE: begin
                lamps_d.state_lamp = 1'b0;
            end
            default: begin
                lamps_d.state_lamp = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            lamps_q <= '0;
        end else begin
            lamps_q <= lamps_d;
        end
    end

    // Pulse time out of range is refused and flagged for one cycle
    assign pls_ok = output_pulse_cmd.valid &&
                    output_pulse_cmd.ms >= PULSE_MIN_MS &&
                    output_pulse_cmd.ms <= PULSE_MAX_MS;

    always_ff @(posedge mclk) begin
        if (reset) begin
            reject_q <= 1'b0;
        end else begin
            reject_q <= output_pulse_cmd.valid && !pls_ok;
        end
    end

    // Per-relay control; a level command beats a pulse to the same port
    for (genvar i = 0; i < NPORTS; i++) begin : g_relay
        logic        on_q;
        logic [13:0] left_q;
        logic        lvl_hit;
        logic        pls_hit;

        assign lvl_hit = output_level_cmd.valid && output_level_cmd.port == 3'(i);
        assign pls_hit = pls_ok && output_pulse_cmd.port == 3'(i);

        // One extra ms so the free-running tick never cuts a pulse short
        always_ff @(posedge mclk) begin
            if (reset) begin
                on_q   <= 1'b0;
                left_q <= 14'h0000;
            end else if (lvl_hit) begin
                on_q   <= output_level_cmd.value;
                left_q <= 14'h0000;
            end else if (pls_hit) begin
                on_q   <= 1'b1;
                left_q <= output_pulse_cmd.ms + 14'h0001;
            end else if (ms_tick && left_q != 14'h0000) begin
                left_q <= left_q - 14'h0001;
                if (left_q == 14'h0001) begin
                    on_q <= 1'b0;
                end
            end
        end

        assign relay_w[i] = on_q;
    end

    // Relay drive is high to close the normally open contact
    assign relay_out            = relay_w;
    assign lamps                = lamps_q;
    assign op_mode              = mode_q;
    assign serial_config_mode   = (mode_q == SLMB_SERIAL_CFG);
    assign firmware_update_mode = (mode_q == SLMB_FW_UPDATE);
    assign pulse_reject         = reject_q;

    AST_LINK_COLOUR: assert property (@(posedge mclk) disable iff (reset)
        (mode_q != SLMB_SERIAL_CFG && link_up) |=>
        (lamps_q.link_green == $past(link_100m) && lamps_q.link_red != $past(link_100m)))
        else $error("link lamp colour does not follow speed");

    AST_RX_IDLE: assert property (@(posedge mclk) disable iff (reset)
        (mode_q != SLMB_SERIAL_CFG && !rx_active) |=> !lamps_q.rx_lamp)
        else $error("receive lamp lit with no traffic");

    AST_TX_BLINK: assert property (@(posedge mclk) disable iff (reset)
        (mode_q != SLMB_SERIAL_CFG && tx_active) |=>
        (lamps_q.tx_lamp == $past(frame_q[0])))
        else $error("transmit lamp not blinking with traffic");

    AST_SEC_FLASH: assert property (@(posedge mclk) disable iff (reset)
        (mode_q == SLMB_NORMAL && addr_assigned && !modbus_connected) |=>
        (lamps_q.state_lamp == ($past(frame_q) == 5'h00 || $past(frame_q) == SEC_TICK)))
        else $error("state lamp not flashing once a second");

    AST_BURST: assert property (@(posedge mclk) disable iff (reset)
        (mode_q == SLMB_NORMAL && !addr_assigned && !modbus_connected) |=>
        (lamps_q.state_lamp == ($past(frame_q) < BURST_TICKS && !$past(frame_q[0]))))
        else $error("state lamp burst pattern wrong");

    AST_INPUT_LAMP: assert property (@(posedge mclk) disable iff (reset)
        (mode_q == SLMB_NORMAL) |=> (lamps_q.input_lamp == $past(din_s_q)))
        else $error("input lamps differ from inputs");

    AST_OUTPUT_LAMP: assert property (@(posedge mclk) disable iff (reset)
        (mode_q == SLMB_NORMAL) |=> (lamps_q.output_lamp == $past(relay_w)))
        else $error("output lamps differ from relays");

    AST_SERIAL_PHASE: assert property (@(posedge mclk) disable iff (reset)
        (mode_q == SLMB_SERIAL_CFG) |=>
        (lamps_q.state_lamp == lamps_q.rx_lamp && lamps_q.rx_lamp == lamps_q.tx_lamp &&
         (lamps_q.link_green || lamps_q.link_red) == lamps_q.state_lamp))
        else $error("serial mode lamps out of phase");

    AST_FW_DARK: assert property (@(posedge mclk) disable iff (reset)
        (mode_q == SLMB_FW_UPDATE) |=> !lamps_q.state_lamp)
        else $error("state lamp lit in firmware update");

    AST_SHORT_ENTERS: assert property (@(posedge mclk) disable iff (reset)
        (short_press && !long_press && mode_q == SLMB_NORMAL) |=>
        (mode_q == SLMB_SERIAL_CFG))
        else $error("short press did not enter serial configuration");

    AST_LONG_ENTERS: assert property (@(posedge mclk) disable iff (reset)
        (long_press || boot_held) |=> (mode_q == SLMB_FW_UPDATE))
        else $error("long or boot press did not enter firmware update");

    AST_LEVEL: assert property (@(posedge mclk) disable iff (reset)
        output_level_cmd.valid |=>
        (relay_out[$past(output_level_cmd.port)] == $past(output_level_cmd.value)))
        else $error("relay ignores level command");

    AST_PULSE_ON: assert property (@(posedge mclk) disable iff (reset)
        (pls_ok && !output_level_cmd.valid) |=> relay_out[$past(output_pulse_cmd.port)])
        else $error("relay not on after pulse command");

    AST_PULSE_REJECT: assert property (@(posedge mclk) disable iff (reset)
        (output_pulse_cmd.valid && (output_pulse_cmd.ms == 14'h0000 ||
         output_pulse_cmd.ms > PULSE_MAX_MS)) |=> pulse_reject)
        else $error("out of range pulse not refused");
endmodule

/* tb/tb_slmb_top.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_slmb_top;
    import slmb_pkg::*;
    // Shortened counts so the run stays small
    localparam int unsigned DEB   = 8;
    localparam int unsigned LNG   = 64;
    localparam int unsigned TCK   = 4;
    localparam int unsigned MSC   = 4;
    localparam int          FRAME = 20 * TCK;
    logic          mclk = 1'b0, reset = 1'b1, link_up = 1'b0, link_100m = 1'b0;
    logic          rx_active = 1'b0, tx_active = 1'b0, addr_assigned = 1'b0;
    logic          modbus_connected = 1'b0, mode_button_n = 1'b1;
    logic [7:0]    digital_in = 8'h00, relay_out;
    slmb_lvl_cmd_t lvl = '0;
    slmb_pls_cmd_t pls = '0;
    slmb_lamps_t   lamps;
    slmb_mode_t    op_mode;
    logic          serial_config_mode, firmware_update_mode, pulse_reject;
    int            err_count = 0, compares = 0;
    int            st, rx, tx, bad, k;
    // 250 MHz clock
    always #2 mclk = ~mclk;
    slmb_top #(.DEB_CYC(DEB), .LONG_CYC(LNG), .TICK_CYC(TCK), .MS_CYC(MSC)) u_slmb_top (
        .mclk(mclk), .reset(reset), .link_up(link_up), .link_100m(link_100m),
        .rx_active(rx_active), .tx_active(tx_active), .addr_assigned(addr_assigned),
        .modbus_connected(modbus_connected), .digital_in(digital_in),
        .mode_button_n(mode_button_n), .output_level_cmd(lvl), .output_pulse_cmd(pls),
        .relay_out(relay_out), .lamps(lamps), .op_mode(op_mode),
        .serial_config_mode(serial_config_mode),
        .firmware_update_mode(firmware_update_mode), .pulse_reject(pulse_reject));
    // Drive and sample just after the edge, so registered outputs have settled
    task automatic tick(input int n = 1);
        repeat (n) begin
            @(posedge mclk);
            #1;
        end
    endtask
    task automatic tally_and_finish();
        $display("counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic send_lvl(input int p, input logic v);
        lvl = '{1'b1, 3'(p), v};
        tick();
        lvl.valid = 1'b0;
    endtask
    task automatic send_pls(input int p, input int ms);
        pls = '{1'b1, 3'(p), 14'(ms)};
        tick();
        pls.valid = 1'b0;
    endtask
    // One full frame covers every phase, so lit counts do not depend on alignment
    task automatic frame_count();
        st = 0; rx = 0; tx = 0; bad = 0;
        repeat (FRAME) begin
            tick();
            st += int'(lamps.state_lamp === 1'b1);
            rx += int'(lamps.rx_lamp === 1'b1);
            tx += int'(lamps.tx_lamp === 1'b1);
            bad += int'(lamps.rx_lamp !== lamps.link_green || lamps.tx_lamp !== lamps.link_green
                        || lamps.state_lamp !== lamps.link_green);
        end
    endtask
    // Bounded wait for a mode; running out ends the run
    task automatic wait_mode(input slmb_mode_t m, input int n);
        k = 0;
        while (op_mode !== m && k < n) begin
            tick();
            k++;
        end
        `CHK(op_mode, m)
        if (op_mode !== m) tally_and_finish();
    endtask
    task automatic t_link();
        link_up = 1'b1; link_100m = 1'b1; tick(3);
        `CHK({lamps.link_green, lamps.link_red}, 2'b10)
        link_100m = 1'b0; tick(3);
        `CHK({lamps.link_green, lamps.link_red}, 2'b01)
        rx_active = 1'b1; tick(2); frame_count();
        `CHK({rx, tx}, {FRAME / 2, 32'h0000_0000})
        rx_active = 1'b0; tx_active = 1'b1; tick(2); frame_count();
        `CHK({rx, tx}, {32'h0000_0000, FRAME / 2})
        tx_active = 1'b0;
        $display("test link and activity done");
    endtask
    task automatic t_state();
        addr_assigned = 1'b1; tick(3); frame_count();
        `CHK(st, 2 * TCK)
        // An open Modbus connection holds the state lamp steadily on
        modbus_connected = 1'b1; tick(3); frame_count();
        `CHK(st, FRAME)
        modbus_connected = 1'b0; addr_assigned = 1'b0; tick(3); frame_count();
        `CHK(st, 4 * TCK)
        digital_in = 8'hA5; tick(4);
        `CHK(lamps.input_lamp, 8'hA5)
        $display("test state and input lamps done");
    endtask
    task automatic t_relay();
        for (int i = 0; i < 8; i++) begin
            send_lvl(i, 1'b1);
            `CHK(relay_out[i], 1'b1)
            tick();
            `CHK(lamps.output_lamp[i], 1'b1)
        end
        // Let an edge pass between commands so valid is never written twice at once
        for (int i = 0; i < 8; i++) begin
            send_lvl(i, 1'b0);
            tick();
        end
        `CHK(relay_out, 8'h00)
        send_pls(0, 2);
        `CHK({relay_out[0], pulse_reject}, 2'b10)
        k = 0;
        while (relay_out[0] === 1'b1 && k < 40) begin
            tick();
            k++;
        end
        `CHK(k >= 2 * MSC && k <= 3 * MSC + 1, 1'b1)
        if (k >= 40) tally_and_finish();
        send_pls(2, 0);
        `CHK({relay_out[2], pulse_reject}, 2'b01)
        tick(); send_pls(2, 10001);
        `CHK({relay_out[2], pulse_reject}, 2'b01)
        tick(); send_pls(2, 10000);
        `CHK({relay_out[2], pulse_reject}, 2'b10)
        send_lvl(2, 1'b0);
        tick(MSC * 2);
        `CHK(relay_out[2], 1'b0)
        $display("test relays done");
    endtask
    task automatic t_button();
        link_100m = 1'b1;
        mode_button_n = 1'b0; tick(DEB / 2); mode_button_n = 1'b1; tick(30);
        `CHK(op_mode, SLMB_NORMAL)
        mode_button_n = 1'b0; tick(DEB + 12); mode_button_n = 1'b1;
        wait_mode(SLMB_SERIAL_CFG, DEB + 20);
        `CHK(serial_config_mode, 1'b1)
        frame_count();
        `CHK({bad, st}, {32'h0000_0000, FRAME / 2})
        mode_button_n = 1'b0;
        wait_mode(SLMB_FW_UPDATE, LNG + 20);
        `CHK(firmware_update_mode, 1'b1)
        mode_button_n = 1'b1; addr_assigned = 1'b1; frame_count();
        `CHK(st, 0)
        $display("test mode button done");
    endtask
    task automatic t_boot();
        reset = 1'b1; mode_button_n = 1'b0; tick(6); reset = 1'b0; tick();
        `CHK(op_mode, SLMB_NORMAL)
        wait_mode(SLMB_FW_UPDATE, DEB + 20);
        mode_button_n = 1'b1; tick(DEB + 20);
        `CHK(op_mode, SLMB_FW_UPDATE)
        $display("test boot hold done");
    endtask
    initial begin
        tick(6);
        reset = 1'b0;
        tick();
        t_link();
        t_state();
        t_relay();
        t_button();
        t_boot();
        tally_and_finish();
    end
endmodule
